//--- verilog/motion_sensor_regs.sv
// register bank of the optical motion sensor behind its two-wire serial port
// assumes: sck and sdio come from the controller, unsynchronised; motion, sample and
// exposure inputs come from the image core on mclk
//
// Contract
// [RULE1] writing one to config top bit resets the part; zero does nothing
// [RULE2] config bit six set switches analog circuitry off
// [RULE3] without stay-awake, sleep after 1500 frames of no movement; else stay awake
// [RULE4] state register bit zero reads one awake, zero asleep
// [RULE5] state register bits seven to five hold fixed part code, four to one zero
// [RULE6] vertical motion accumulates signed Y movement and clears when read
// [RULE7] horizontal motion accumulates signed X movement and clears when read
// [RULE8] surface quality is upper eight bits of nine-bit feature count
// [RULE9] brightest sample holds frame maximum, top two bits zero
// [RULE10] darkest sample holds frame minimum, top two bits zero, resets to 0x3f
// [RULE11] brightness total is upper eight bits of fifteen-bit sample sum
// [RULE12] brightness total never exceeds 159
// [RULE13] image port: frame begin bit seven, valid bit six, sample in five to zero
// [RULE14] any image port write restarts grabber at sample one with frame begin
// [RULE15] each further image port read of a held sample advances the sample index
// [RULE16] grabber captures at most one sample per frame
// [RULE17] valid flag set only while grabber holds a sample
// [RULE18] after sample 324 the index wraps to sample one
// [RULE19] any image port access arms grabber; sample held until read
// [RULE20] controller sets stay-awake, writes port, collects 324 valid reads
// [RULE21] registers reached only through the serial port
// [RULE22] unassigned addresses ignore writes and read zero
// [RULE23] part reset bit clears itself after the reset
// [RULE24] reserved config bits ignored on write, read zero
// [RULE25] reading port without held sample gives valid clear, index unchanged
`timescale 1ns/1ps
`default_nettype none
`include "sensor_consts.svh"

module motion_sensor_regs
   import sensor_pkg::*;
#(
   parameter logic [2:0] PART_CODE = 3'h5 // arbitrary value
)(
   input wire logic mclk,
   input wire logic reset,
   input wire logic sck,
   input wire logic sdio_in,
   output logic sdio_out,
   output logic sdio_oe_n,
   output logic analog_shutdown,
   output logic awake,
   input wire logic motion_valid,
   input wire logic [7:0] motion_dx,
   input wire logic [7:0] motion_dy,
   input wire logic sample_valid,
   input wire logic sample_first,
   input wire logic sample_last,
   input wire logic [5:0] sample_value,
   input wire logic [8:0] feature_count,
   input wire logic [15:0] exposure
);
   frame_stats_if st ();

   logic sck_s1, sck_s2, sck_s3;
   logic sdio_s1, sdio_s2;
   logic sck_rise, sck_fall;
   port_state_t state_q;
   logic [3:0] cnt_q;
   logic [7:0] shift_q;
   logic [6:0] addr_q;
   reg_byte_t wdata_q;
   logic rd_stb_q, wr_stb_q;
   reg_byte_t tx_q;
   logic drive_q;
   reg_byte_t rd_mux;
   logic soft_rst_q;
   logic core_rst;
   logic shutdown_q, stay_q;
   logic [7:0] dy_q, dx_q;
   logic rd_vert, rd_horz;
   logic awake_q;
   logic [10:0] idle_q;
   logic [8:0] index_q;
   logic armed_q, seen_q, held_q;
   logic [5:0] grab_q;
   logic grab_wr, grab_rd, grab_hit;
   reg_byte_t grab_byte;

   // ==========================================
   // helpers
   function automatic logic [7:0] sat_add(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] s;
      s = {a[7], a} + {b[7], b};
      if (s[8] != s[7])
         sat_add = s[8] ? 8'h80 : 8'h7f;
      else
         sat_add = s[7:0];
   endfunction

   function automatic logic access_to(input logic stb, input logic [6:0] a,
      input logic [6:0] target);
      access_to = stb && (a == target);
   endfunction

   // ==========================================
   // pin synchronisers, edges found from the second and third stage; sck stages reset high
   always_ff @(posedge mclk) begin
      if (reset) begin
         sck_s1 <= 1'b1; // idle level of sck, so no false rise follows reset
         sck_s2 <= 1'b1;
         sck_s3 <= 1'b1;
         sdio_s1 <= 1'b0;
         sdio_s2 <= 1'b0;
      end else begin
         sck_s1 <= sck;
         sck_s2 <= sck_s1;
         sck_s3 <= sck_s2;
         sdio_s1 <= sdio_in;
         sdio_s2 <= sdio_s1;
      end
   end

   assign sck_rise = sck_s2 & ~sck_s3;
   assign sck_fall = ~sck_s2 & sck_s3;

   // ==========================================
   // serial sequencer: direction bit and address, then eight data bits
   always_ff @(posedge mclk) begin
      if (reset) begin
         state_q <= PORT_ADDR;
         cnt_q <= 4'h0;
         shift_q <= 8'h0;
         addr_q <= 7'h0;
         wdata_q <= 8'h0;
         rd_stb_q <= 1'b0;
         wr_stb_q <= 1'b0;
      end else begin
         rd_stb_q <= 1'b0;
         wr_stb_q <= 1'b0;
         case (state_q)
            PORT_ADDR: begin
               if (sck_rise) begin
                  shift_q <= {shift_q[6:0], sdio_s2};
                  cnt_q <= cnt_q + 4'h1;
                  if (cnt_q == `SERIAL_BITS - 4'h1) begin
                     addr_q <= {shift_q[5:0], sdio_s2};
                     cnt_q <= 4'h0;
                     if (shift_q[6]) begin
                        state_q <= PORT_WDATA;
                     end else begin
                        rd_stb_q <= 1'b1; // RULE21
                        state_q <= PORT_RDATA;
                     end
                  end
               end
            end
            PORT_WDATA: begin
               if (sck_rise) begin
                  shift_q <= {shift_q[6:0], sdio_s2};
                  cnt_q <= cnt_q + 4'h1;
                  if (cnt_q == `SERIAL_BITS - 4'h1) begin
                     wdata_q <= {shift_q[6:0], sdio_s2};
                     wr_stb_q <= 1'b1; // RULE21
                     cnt_q <= 4'h0;
                     state_q <= PORT_ADDR;
                  end
               end
            end
            PORT_RDATA: begin
               if (sck_rise) begin
                  cnt_q <= cnt_q + 4'h1;
               end else if (sck_fall && cnt_q == `SERIAL_BITS) begin
                  cnt_q <= 4'h0;
                  state_q <= PORT_ADDR;
               end
            end
            default: begin
               state_q <= PORT_ADDR;
            end
         endcase
      end
   end

   // ==========================================
   // read shifter: drives data from the strobe, shifts on falls, lets go after last
   always_ff @(posedge mclk) begin
      if (reset) begin
         tx_q <= 8'h0;
         drive_q <= 1'b0;
      end else if (rd_stb_q) begin
         tx_q <= rd_mux;
         drive_q <= 1'b1;
      end else if (state_q == PORT_RDATA && sck_fall) begin
         if (cnt_q == `SERIAL_BITS)
            drive_q <= 1'b0;
         else if (cnt_q != 4'h0)
            tx_q <= {tx_q[6:0], 1'b0};
      end
   end

   assign sdio_out = tx_q[7];
   assign sdio_oe_n = ~drive_q;

   // ==========================================
   // read multiplexer
   always_comb begin
      case (addr_q)
         `ADDR_SENSOR_CONFIG: rd_mux = {1'b0, shutdown_q, 5'h0, stay_q}; // RULE23 RULE24
         `ADDR_SENSOR_STATE: rd_mux = {PART_CODE, 4'h0, awake_q}; // RULE4 RULE5
         `ADDR_VERTICAL_MOTION: rd_mux = dy_q;
         `ADDR_HORIZONTAL_MOTION: rd_mux = dx_q;
         `ADDR_SURFACE_QUALITY: rd_mux = st.surface; // RULE8
         `ADDR_BRIGHTEST_SAMPLE: rd_mux = {2'h0, st.brightest}; // RULE9
         `ADDR_DARKEST_SAMPLE: rd_mux = {2'h0, st.darkest}; // RULE10
         `ADDR_BRIGHTNESS_TOTAL: rd_mux = st.total; // RULE11
         `ADDR_IMAGE_SAMPLE_PORT: rd_mux = grab_byte; // RULE13
         `ADDR_EXPOSURE_HIGH_BYTE: rd_mux = exposure[15:8];
         `ADDR_EXPOSURE_LOW_BYTE: rd_mux = exposure[7:0];
         `ADDR_COMPLEMENT_PART_CODE: rd_mux = {4'h0, ~{1'b0, PART_CODE}};
         default: rd_mux = 8'h00; // RULE22
      endcase
   end

   // ==========================================
   // configuration; survives the part reset it triggers, reset bit never stored
   always_ff @(posedge mclk) begin
      if (reset) begin
         shutdown_q <= 1'b0;
         stay_q <= 1'b0;
         soft_rst_q <= 1'b0;
      end else begin
         soft_rst_q <= access_to(wr_stb_q, addr_q, `ADDR_SENSOR_CONFIG)
            && wdata_q[`PART_RESET_BIT]; // RULE1 RULE23
         if (access_to(wr_stb_q, addr_q, `ADDR_SENSOR_CONFIG)) begin
            shutdown_q <= wdata_q[`ANALOG_SHUTDOWN_BIT]; // RULE2
            stay_q <= wdata_q[`STAY_AWAKE_BIT];
         end
      end
   end

   assign core_rst = reset | soft_rst_q; // RULE1
   assign analog_shutdown = shutdown_q; // RULE2

   // ==========================================
   // motion accumulators; movement in the clearing cycle is kept
   assign rd_vert = access_to(rd_stb_q, addr_q, `ADDR_VERTICAL_MOTION);
   assign rd_horz = access_to(rd_stb_q, addr_q, `ADDR_HORIZONTAL_MOTION);

   always_ff @(posedge mclk) begin
      if (core_rst) begin
         dy_q <= 8'h0;
         dx_q <= 8'h0;
      end else begin
         if (motion_valid)
            dy_q <= sat_add(rd_vert ? 8'h0 : dy_q, motion_dy); // RULE6
         else if (rd_vert)
            dy_q <= 8'h0; // RULE6
         if (motion_valid)
            dx_q <= sat_add(rd_horz ? 8'h0 : dx_q, motion_dx); // RULE7
         else if (rd_horz)
            dx_q <= 8'h0; // RULE7
      end
   end

   // ==========================================
   // sleep timer counted in frames
   always_ff @(posedge mclk) begin
      if (core_rst) begin
         awake_q <= 1'b1;
         idle_q <= 11'h0;
      end else if (stay_q || (motion_valid && (motion_dx != 8'h0 || motion_dy != 8'h0))) begin
         awake_q <= 1'b1; // RULE3
         idle_q <= 11'h0;
      end else if (st.frame_done && awake_q) begin
         idle_q <= idle_q + 11'h1;
         if (idle_q == 11'(`SLEEP_FRAMES - 1))
            awake_q <= 1'b0; // RULE3
      end
   end

   assign awake = awake_q;

   // ==========================================
   // frame grabber
   assign st.sample_valid = sample_valid;
   assign st.sample_first = sample_first;
   assign st.sample_last = sample_last;
   assign st.sample_value = sample_value;
   assign st.feature_count = feature_count;

   frame_stats u_stats (
      .mclk(mclk),
      .core_rst(core_rst),
      .st(st)
   );

   assign grab_wr = access_to(wr_stb_q, addr_q, `ADDR_IMAGE_SAMPLE_PORT);
   assign grab_rd = access_to(rd_stb_q, addr_q, `ADDR_IMAGE_SAMPLE_PORT);
   assign grab_hit = armed_q && sample_valid && (seen_q || sample_first)
      && st.cur_pos == index_q;

   always_ff @(posedge mclk) begin
      if (core_rst) begin
         index_q <= 9'd1;
         armed_q <= 1'b0;
         seen_q <= 1'b0;
         held_q <= 1'b0;
         grab_q <= 6'h0;
      end else if (grab_wr) begin
         index_q <= 9'd1; // RULE14
         held_q <= 1'b0;
         armed_q <= 1'b1; // RULE19
         seen_q <= 1'b0;
      end else if (grab_rd && held_q) begin
         armed_q <= 1'b1; // RULE19
         held_q <= 1'b0;
         seen_q <= 1'b0;
         index_q <= (index_q == `SAMPLES_PER_FRAME) ? 9'd1 : 9'(index_q + 9'd1); // RULE15 RULE18
      end else if (grab_hit) begin
         // a capture in the cycle of an empty read still lands: the set wins
         grab_q <= sample_value; // RULE16
         held_q <= 1'b1; // RULE17
         armed_q <= 1'b0; // RULE16
      end else if (grab_rd) begin
         armed_q <= 1'b1; // RULE19
         if (!armed_q)
            seen_q <= 1'b0; // RULE25
      end else if (armed_q && sample_valid && sample_first) begin
         seen_q <= 1'b1;
      end
   end

   assign grab_byte = {held_q && index_q == 9'd1, held_q, held_q ? grab_q : 6'h0}; // RULE13 RULE17

   // ==========================================
   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   sequence cfg_write_reset;
      wr_stb_q && addr_q == `ADDR_SENSOR_CONFIG && wdata_q[`PART_RESET_BIT];
   endsequence

   part_reset_pulse_a: assert property (cfg_write_reset |=> soft_rst_q ##1 !soft_rst_q) // RULE1 RULE23
      else $error("part reset did not pulse once");
   shutdown_follow_a: assert property ( // RULE2
      wr_stb_q && addr_q == `ADDR_SENSOR_CONFIG |=> analog_shutdown == $past(wdata_q[6]))
      else $error("analog shutdown does not follow config write");
   stay_awake_a: assert property (stay_q && !soft_rst_q |=> awake) // RULE3
      else $error("asleep while stay-awake set");
   vert_clear_a: assert property (rd_vert && !motion_valid && !soft_rst_q |=> dy_q == 8'h0) // RULE6
      else $error("vertical motion not cleared by read");
   horz_clear_a: assert property (rd_horz && !motion_valid && !soft_rst_q |=> dx_q == 8'h0) // RULE7
      else $error("horizontal motion not cleared by read");
   grab_restart_a: assert property (grab_wr && !soft_rst_q |=> index_q == 9'd1 && !held_q) // RULE14
      else $error("image port write did not restart grabber");
   grab_wrap_a: assert property ( // RULE18
      grab_rd && held_q && index_q == 9'd324 && !soft_rst_q |=> index_q == 9'd1)
      else $error("sample index did not wrap");
   grab_idle_a: assert property (grab_rd && !held_q && !soft_rst_q |=> $stable(index_q)) // RULE25
      else $error("index moved on read without sample");
   read_release_a: assert property ( // RULE21
      state_q == PORT_RDATA && sck_fall && cnt_q == 4'd8 |=> sdio_oe_n)
      else $error("sdio not released after read");
   state_code_a: assert property (rd_stb_q && addr_q == `ADDR_SENSOR_STATE // RULE4 RULE5
      |=> tx_q == {PART_CODE, 4'h0, $past(awake_q)} ##0 !sdio_oe_n)
      else $error("state register read wrong");
endmodule // motion_sensor_regs

`default_nettype wire

//--- common/sensor_consts.svh
// register addresses, field positions, reset values and counts of the motion sensor
// assumes: included by bare name from the design files
`ifndef SENSOR_CONSTS_SVH
`define SENSOR_CONSTS_SVH

// ==========================================
// register addresses (7-bit serial address)
`define ADDR_SENSOR_CONFIG 7'h00
`define ADDR_SENSOR_STATE 7'h01
`define ADDR_VERTICAL_MOTION 7'h02
`define ADDR_HORIZONTAL_MOTION 7'h03
`define ADDR_SURFACE_QUALITY 7'h04
`define ADDR_BRIGHTEST_SAMPLE 7'h05
`define ADDR_DARKEST_SAMPLE 7'h06
`define ADDR_BRIGHTNESS_TOTAL 7'h07
`define ADDR_IMAGE_SAMPLE_PORT 7'h08
`define ADDR_EXPOSURE_HIGH_BYTE 7'h09
`define ADDR_EXPOSURE_LOW_BYTE 7'h0a
`define ADDR_COMPLEMENT_PART_CODE 7'h11

// ==========================================
// field positions
`define PART_RESET_BIT 7
`define ANALOG_SHUTDOWN_BIT 6
`define STAY_AWAKE_BIT 0
`define FRAME_BEGIN_FLAG 7
`define DATA_VALID_FLAG 6

// ==========================================
// reset values and counts
`define DARKEST_RESET 6'h3f
`define SAMPLES_PER_FRAME 9'd324
`define FRAME_RATE_HZ 1500
`define SLEEP_TIME_S 1
`define SLEEP_FRAMES (`FRAME_RATE_HZ * `SLEEP_TIME_S)
`define SERIAL_BITS 4'd8

`endif

//--- common/sensor_pkg.sv
// types shared by the motion sensor register block
// assumes: constants come from sensor_consts.svh
package sensor_pkg;

   // ==========================================
   // serial port sequencer states
   typedef enum logic [2:0] {
      PORT_ADDR = 3'b001,
      PORT_WDATA = 3'b010,
      PORT_RDATA = 3'b100
   } port_state_t;

   typedef logic [7:0] reg_byte_t;

endpackage

//--- common/frame_stats_if.sv
// sample stream and per-frame statistics between register block and statistics unit
// assumes: one clock domain, mclk
`timescale 1ns/1ps
`default_nettype none

interface frame_stats_if;
   logic sample_valid;
   logic sample_first;
   logic sample_last;
   logic [5:0] sample_value;
   logic [8:0] feature_count;
   logic [8:0] cur_pos;
   logic frame_done;
   logic [5:0] brightest;
   logic [5:0] darkest;
   logic [7:0] total;
   logic [7:0] surface;

   modport source (output sample_valid, sample_first, sample_last, sample_value,
      feature_count, input cur_pos, frame_done, brightest, darkest, total, surface);
   modport stats (input sample_valid, sample_first, sample_last, sample_value,
      feature_count, output cur_pos, frame_done, brightest, darkest, total, surface);
endinterface

`default_nettype wire

//--- verilog/frame_stats.sv
// per-frame brightest, darkest, total and surface quality figures
// assumes: sample stream on mclk, first and last flags mark frame bounds
`timescale 1ns/1ps
`default_nettype none
`include "sensor_consts.svh"

module frame_stats
   import sensor_pkg::*;
(
   input wire logic mclk,
   input wire logic core_rst,
   frame_stats_if.stats st
);
   logic [5:0] run_max_q;
   logic [5:0] run_min_q;
   logic [14:0] run_sum_q;
   logic [8:0] pos_q;
   logic [5:0] bright_q;
   logic [5:0] dark_q;
   logic [7:0] total_q;
   logic [7:0] surface_q;
   logic done_q;
   logic [5:0] mx;
   logic [5:0] mn;
   logic [14:0] sm;

   // ==========================================
   // running figures, first sample restarts them
   always_comb begin
      mx = st.sample_first ? st.sample_value :
         (st.sample_value > run_max_q ? st.sample_value : run_max_q);
      mn = st.sample_first ? st.sample_value :
         (st.sample_value < run_min_q ? st.sample_value : run_min_q);
      sm = (st.sample_first ? 15'h0 : run_sum_q) + {9'h0, st.sample_value};
   end

   assign st.cur_pos = st.sample_first ? 9'd1 : 9'(pos_q + 9'd1);

   always_ff @(posedge mclk) begin
      if (core_rst) begin
         run_max_q <= 6'h0;
         run_min_q <= `DARKEST_RESET;
         run_sum_q <= 15'h0;
         pos_q <= 9'h0;
      end else if (st.sample_valid) begin
         run_max_q <= mx;
         run_min_q <= mn;
         run_sum_q <= sm;
         pos_q <= st.cur_pos;
      end
   end

   // ==========================================
   // frame results latched on the last sample
   always_ff @(posedge mclk) begin
      if (core_rst) begin
         bright_q <= 6'h0;
         dark_q <= `DARKEST_RESET; // RULE10
         total_q <= 8'h0;
         surface_q <= 8'h0;
         done_q <= 1'b0;
      end else begin
         done_q <= st.sample_valid & st.sample_last;
         if (st.sample_valid && st.sample_last) begin
            bright_q <= mx; // RULE9
            dark_q <= mn; // RULE10
            total_q <= sm[14:7]; // RULE11
            surface_q <= st.feature_count[8:1]; // RULE8
         end
      end
   end

   assign st.brightest = bright_q;
   assign st.darkest = dark_q;
   assign st.total = total_q;
   assign st.surface = surface_q;
   assign st.frame_done = done_q;

   // ==========================================
   // checks
   total_cap_a: assert property (@(posedge mclk) disable iff (core_rst) total_q <= 8'd159) // RULE12
      else $error("brightness total above 159");
   dark_min_a: assert property (@(posedge mclk) disable iff (core_rst) // RULE10
      st.sample_valid && st.sample_last && !st.sample_first |=> dark_q <= $past(run_min_q))
      else $error("darkest sample not a frame minimum");
endmodule // frame_stats

`default_nettype wire

//--- bench/serial_master.sv
// controller model driving the sensor's two-wire serial port
// assumes: sdio_line is the resolved pin level; sck idles high between transactions
`timescale 1ns/1ps
`default_nettype none

module serial_master (
   input wire logic mclk,
   input wire logic sdio_line,
   output logic sck,
   output logic sdio_drv,
   output logic sdio_en
);
   initial begin
      sck = 1'b1;
      sdio_drv = 1'b0;
      sdio_en = 1'b0;
   end

   // wait n system cycles, then step just past the edge
   task automatic wait_n(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   // =============================================
   // one transaction: direction, 7 address bits, 8 data bits, msb first
   task automatic xfer(input logic wr, input logic [6:0] addr, input logic [7:0] wdata,
         output logic [7:0] rdata);
      logic [15:0] bits;
      bits = {wr, addr, wdata};
      rdata = 8'h00;
      for (int i = 15; i >= 0; i--) begin
         sck = 1'b0;
         wait_n(8); // lets the device drop the line after a previous read
         if (wr || i >= 8) begin
            sdio_en = 1'b1;
            sdio_drv = bits[i];
         end
         wait_n(8);
         if (!wr && i < 8) rdata[i] = sdio_line;
         sck = 1'b1;
         if (!wr && i == 8) begin
            wait_n(1);
            sdio_en = 1'b0; // hand the line over before the device answers
         end
         wait_n(16);
      end
      wait_n(64); // turnaround gap before the next transaction
   endtask
endmodule // serial_master

`default_nettype wire

//--- bench/motion_sensor_register_map_tb.sv
// self-checking bench of the motion sensor register block
// assumes: serial_master model, 200 MHz mclk, serial clock of 160 ns
`timescale 1ns/1ps
`default_nettype none

module motion_sensor_register_map_tb;
   import sensor_pkg::*;
`define CHK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin err_count++; \
   $display("ERROR %s expected %h seen %h", what, exp, got); end end

   localparam logic [2:0] PC = 3'h5; // arbitrary part code
   logic mclk = 1'b0, reset = 1'b1, sck, sdio_drv, sdio_en, sdio_line, line_last = 1'b0;
   logic sdio_out, sdio_oe_n, analog_shutdown, awake, motion_valid = 1'b0;
   logic [7:0] motion_dx = 8'h00, motion_dy = 8'h00;
   logic sample_valid = 1'b0, sample_first = 1'b0, sample_last = 1'b0;
   logic [5:0] sample_value = 6'h00, mx, mn;
   logic [8:0] feature_count = 9'h000;
   logic [15:0] exposure = 16'h1234;
   logic [14:0] sum;
   int err_count = 0, comparisons = 0, cycles = 0;

   // clock, timeout and resolved data pin (released line flips every cycle)
   always #2.5 mclk = ~mclk;
   always_comb sdio_line = !sdio_oe_n ? sdio_out : (sdio_en ? sdio_drv : ~line_last);
   always @(posedge mclk) begin
      line_last <= sdio_line;
      cycles++;
      if (cycles == 60000) begin
         err_count++;
         report_and_stop();
      end
   end

   serial_master i_serial_master (.mclk(mclk), .sdio_line(sdio_line), .sck(sck),
      .sdio_drv(sdio_drv), .sdio_en(sdio_en));

   motion_sensor_regs #(.PART_CODE(PC)) i_motion_sensor_regs (.mclk(mclk), .reset(reset),
      .sck(sck), .sdio_in(sdio_line), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
      .analog_shutdown(analog_shutdown), .awake(awake), .motion_valid(motion_valid),
      .motion_dx(motion_dx), .motion_dy(motion_dy), .sample_valid(sample_valid),
      .sample_first(sample_first), .sample_last(sample_last), .sample_value(sample_value),
      .feature_count(feature_count), .exposure(exposure));

   // =============================================
   // access and stimulus tasks
   task automatic tick();
      @(posedge mclk);
      #1;
   endtask

   task automatic wr(input logic [6:0] a, input reg_byte_t d);
      reg_byte_t unused;
      i_serial_master.xfer(1'b1, a, d, unused);
   endtask

   task automatic rd(input logic [6:0] a, input reg_byte_t exp);
      reg_byte_t got;
      i_serial_master.xfer(1'b0, a, 8'h00, got);
      `CHK($sformatf("reg %h", a), exp, got);
   endtask

   task automatic move(input logic [7:0] dx, input logic [7:0] dy);
      motion_dx = dx;
      motion_dy = dy;
      motion_valid = 1'b1;
      tick();
      motion_valid = 1'b0;
      tick();
   endtask

   // full 324-sample frame; tracks expected max, min and sum
   task automatic frame(input logic [5:0] base, input logic [5:0] step, input logic [8:0] f);
      logic [5:0] v;
      mx = 6'h00;
      mn = 6'h3f;
      sum = 15'h0000;
      feature_count = f;
      for (int i = 1; i <= 324; i++) begin
         v = base + step * 6'(i);
         sample_value = v;
         sample_valid = 1'b1;
         sample_first = (i == 1);
         sample_last = (i == 324);
         if (v > mx) mx = v;
         if (v < mn) mn = v;
         sum = sum + 15'(v);
         tick();
      end
      sample_valid = 1'b0;
      sample_last = 1'b0;
      repeat (4) tick();
   endtask

   // one-sample frames with no movement; first and last both set so each frame restarts
   task automatic blank(input int n);
      repeat (n) begin
         sample_valid = 1'b1;
         sample_first = 1'b1;
         sample_last = 1'b1;
         tick();
         sample_valid = 1'b0;
         sample_first = 1'b0;
         sample_last = 1'b0;
         tick();
      end
   endtask

   task automatic report_and_stop();
      if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // =============================================
   // main sequence
   initial begin
      repeat (12) tick();
      reset = 1'b0;
      repeat (4) tick();
      `CHK("awake", 1'b1, awake);
      `CHK("oe_n", 1'b1, sdio_oe_n);
      rd(7'h01, {PC, 4'h0, 1'b1});
      rd(7'h02, 8'h00);
      rd(7'h03, 8'h00);
      rd(7'h04, 8'h00);
      rd(7'h06, 8'h3f);
      rd(7'h07, 8'h00);
      rd(7'h08, 8'h00);
      rd(7'h09, 8'h12);
      rd(7'h0a, 8'h34);
      rd(7'h11, {4'h0, ~{1'b0, PC}});
      rd(7'h77, 8'h00);
      wr(7'h00, 8'h7f);
      rd(7'h00, 8'h41);
      `CHK("shutdown", 1'b1, analog_shutdown);
      wr(7'h77, 8'hff);
      rd(7'h00, 8'h41);
      move(8'h03, 8'h03);
      wr(7'h00, 8'h80);
      rd(7'h00, 8'h00);
      `CHK("shutdown", 1'b0, analog_shutdown);
      rd(7'h03, 8'h00);
      move(8'h05, 8'hfd);
      move(8'h05, 8'hfd);
      rd(7'h03, 8'h0a);
      rd(7'h02, 8'hfa);
      rd(7'h03, 8'h00);
      rd(7'h02, 8'h00);
      frame(6'h3f, 6'h00, 9'h1ff);
      rd(7'h07, 8'd159);
      rd(7'h04, 8'hff);
      frame(6'h00, 6'h07, 9'h0a5);
      rd(7'h05, {2'b00, mx});
      rd(7'h06, {2'b00, mn});
      rd(7'h07, sum[14:7]);
      rd(7'h04, 8'h52);
      wr(7'h00, 8'h01);
      wr(7'h08, 8'h5a);
      frame(6'd10, 6'd3, 9'h000);
      frame(6'd20, 6'd1, 9'h000);
      rd(7'h08, 8'hcd);
      rd(7'h08, 8'h00);
      frame(6'd20, 6'd1, 9'h000);
      rd(7'h08, 8'h56);
      blank(1501);
      `CHK("awake", 1'b1, awake);
      wr(7'h00, 8'h00);
      move(8'h01, 8'h00);
      blank(1499);
      `CHK("awake", 1'b1, awake);
      blank(2);
      `CHK("awake", 1'b0, awake);
      rd(7'h01, {PC, 4'h0, 1'b0});
      report_and_stop();
   end
endmodule // motion_sensor_register_map_tb

`default_nettype wire
